// ### hdl/qpsr_cmd.sv
`timescale 1ns/100ps
`default_nettype none
module qpsr_cmd
  import qpsr_pkg::*;
(
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         nrst,
  // Serial bus pins, sampled on clk.
  input  wire qpsr_pin_in_t pins,
  output logic [3:0]        dq_out,
  output logic [3:0]        dq_oe,
  // Status.
  output logic              quad_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Shift one bit or one nibble into an accumulator.
  function automatic logic [ADDR_W-1:0] shift_in(logic [ADDR_W-1:0] a, logic w, logic [3:0] d);
    return w ? {a[ADDR_W-5:0], d} : {a[ADDR_W-2:0], d[0]};
  endfunction

  // Lane pattern for the top unit of a byte.
  function automatic logic [3:0] out_unit(logic [7:0] b, logic w);
    return w ? b[7:4] : {2'h0, b[7], 1'h0};
  endfunction

  // Byte after its top unit has left.
  function automatic logic [7:0] shift_out(logic [7:0] b, logic w);
    return w ? {b[3:0], 4'h0} : {b[6:0], 1'h0};
  endfunction

  function automatic logic [4:0] unit_last(logic w);
    return w ? UNIT_QD_LAST : UNIT_SER_LAST;
  endfunction

  // Next burst address: the column wraps inside the page.
  function automatic logic [ADDR_W-1:0] page_next(logic [ADDR_W-1:0] a);
    return {a[ADDR_W-1:PAGE_W], a[PAGE_W-1:0] + {{(PAGE_W-1){1'b0}}, 1'b1}};
  endfunction

  // Open an access after its command byte.
  function automatic qpsr_regs_t begin_access(qpsr_regs_t r, logic w, logic rd, logic [4:0] wt);
    qpsr_regs_t n;
    n         = r;
    n.state   = S_ADDR;
    n.wide    = w;
    n.is_read = rd;
    n.waits   = wt;
    n.cnt     = w ? ADDR_QD_LAST : ADDR_SER_LAST;
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State and edge detection.
  localparam qpsr_regs_t RESET_REGS = '{state: S_CMD, cnt: UNIT_SER_LAST, default: '0};

  qpsr_regs_t        st;
  qpsr_regs_t        nx;
  logic              rise;
  logic              fall;
  logic              cmd_fire;
  logic [ADDR_W-1:0] in_word;
  logic [7:0]        cmd_code;
  logic              wr_en;
  logic [7:0]        wr_data;
  logic [7:0]        rd_data;

  // Host clock edges count only inside a frame.
  assign rise     = !pins.ce_n && !st.sclk_prev && pins.sclk;
  assign fall     = !pins.ce_n && st.sclk_prev && !pins.sclk;
  assign in_word  = shift_in(st.sh, st.wide, pins.dq);
  assign cmd_code = in_word[7:0];
  assign cmd_fire = st.state == S_CMD && rise && st.cnt == '0;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  always_comb begin
    nx           = st;
    wr_en        = 1'b0;
    wr_data      = in_word[7:0];
    nx.sclk_prev = pins.sclk;
    if (pins.ce_n) begin
      // Chip select high ends any access and readies the next command.
      nx.state  = S_CMD;
      nx.wide   = st.quad;
      nx.cnt    = unit_last(st.quad);
      nx.dq_out = '0;
      nx.dq_oe  = '0;
    end else begin
      case (st.state)
        S_CMD: begin
          if (rise) begin
            nx.sh  = in_word;
            nx.cnt = st.cnt - 5'h1;
            if (st.cnt == '0) begin
              nx.cmd   = cmd_code;
              nx.state = S_SKIP;
              nx.armed = 1'b0;
              case (cmd_code)
                CMD_RESET_ARM:  nx.armed = 1'b1;
                CMD_RESET:      if (st.armed) nx.quad = 1'b0;
                CMD_QUAD_ENTER: if (!st.quad) nx.quad = 1'b1;
                CMD_QUAD_EXIT:  if (st.quad) nx.quad = 1'b0;
                CMD_READ_SLOW:  if (!st.quad) nx = begin_access(nx, 1'b0, 1'b1, WAIT_NONE);
                CMD_READ_FAST:  nx = begin_access(nx, st.quad, 1'b1,
                                  st.quad ? WAIT_QD_FAST : WAIT_SER_FAST);
                CMD_READ_QUAD:  nx = begin_access(nx, 1'b1, 1'b1, WAIT_QD_READ);
                CMD_WRITE:      nx = begin_access(nx, st.quad, 1'b0, WAIT_NONE);
                CMD_WRITE_QUAD: nx = begin_access(nx, 1'b1, 1'b0, WAIT_NONE);
                default:        nx.state = S_SKIP;
              endcase
            end
          end
        end
        S_ADDR: begin
          if (rise) begin
            nx.sh  = in_word;
            nx.cnt = st.cnt - 5'h1;
            if (st.cnt == '0) begin
              nx.addr = in_word;
              if (!st.is_read) begin
                nx.state = S_WDATA;
                nx.cnt   = unit_last(st.wide);
              end else if (st.waits == WAIT_NONE) begin
                nx.state = S_RDATA;
                nx.cnt   = '0;
              end else begin
                nx.state = S_WAIT;
                nx.cnt   = st.waits - 5'h1;
              end
            end
          end
        end
        S_WAIT: begin
          if (rise) begin
            nx.cnt = st.cnt - 5'h1;
            if (st.cnt == '0) begin
              nx.state = S_RDATA;
              nx.cnt   = '0;
            end
          end
        end
        S_RDATA: begin
          // Launching on the falling edge gives the host a full half period.
          if (fall) begin
            nx.dq_oe = st.wide ? OE_QUAD : OE_SERIAL;
            if (st.cnt == '0) begin
              nx.dq_out  = out_unit(rd_data, st.wide);
              nx.sh[7:0] = shift_out(rd_data, st.wide);
              nx.addr    = page_next(st.addr);
              nx.cnt     = unit_last(st.wide);
            end else begin
              nx.dq_out  = out_unit(st.sh[7:0], st.wide);
              nx.sh[7:0] = shift_out(st.sh[7:0], st.wide);
              nx.cnt     = st.cnt - 5'h1;
            end
          end
        end
        S_WDATA: begin
          if (rise) begin
            nx.sh  = in_word;
            nx.cnt = st.cnt - 5'h1;
            if (st.cnt == '0) begin
              wr_en   = 1'b1;
              nx.addr = page_next(st.addr);
              nx.cnt  = unit_last(st.wide);
            end
          end
        end
        S_SKIP: nx.state = S_SKIP;
        default: nx.state = S_SKIP;
      endcase
    end
  end

  // State register; reset leaves the device in serial standby with nothing armed.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= RESET_REGS;
    end else begin
      st <= nx;
    end
  end

  assign dq_out    = st.dq_out;
  assign dq_oe     = st.dq_oe;
  assign quad_mode = st.quad;

  ////////////////////////////////////////////////////////////////////////////
  // Page storage.
  qpsr_page_mem u_mem (
    .clk     (clk),
    .wr_en   (wr_en),
    .wr_addr (st.addr[PAGE_W-1:0]),
    .wr_data (wr_data),
    .rd_addr (st.addr[PAGE_W-1:0]),
    .rd_data (rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // Output lanes may move only one cycle after a detected falling edge or a deselect.
  data_on_fall_a: assert property (
    $changed(st.dq_out) |-> $past(fall) || $past(pins.ce_n))
    else $error("read data changed away from a falling clock edge");
  quad_exit_a: assert property (
    cmd_fire && st.quad && cmd_code == CMD_QUAD_EXIT |=> !st.quad)
    else $error("quad exit did not clear the mode flag");
  exit_ignored_a: assert property (
    cmd_fire && !st.quad && cmd_code == CMD_QUAD_EXIT |=> !st.quad ##1 !st.quad)
    else $error("quad exit in serial mode changed the mode");
  quad_enter_a: assert property (
    cmd_fire && !st.quad && cmd_code == CMD_QUAD_ENTER |=> st.quad)
    else $error("quad entry did not set the mode flag");
  reset_done_a: assert property (
    cmd_fire && st.armed && cmd_code == CMD_RESET |=> !st.quad && !st.armed)
    else $error("armed reset did not return to serial mode");
  arm_drop_a: assert property (
    cmd_fire && st.armed && cmd_code != CMD_RESET_ARM |=> !st.armed)
    else $error("armed state survived another command");
  unarmed_reset_a: assert property (
    cmd_fire && !st.armed && st.quad && cmd_code == CMD_RESET |=> st.quad)
    else $error("reset acted without a preceding arm");
  quad_write_a: assert property (
    cmd_fire && st.quad && (cmd_code == CMD_WRITE || cmd_code == CMD_WRITE_QUAD)
    |=> st.state == S_ADDR && st.wide && !st.is_read && st.cnt == ADDR_QD_LAST)
    else $error("quad write codes not treated alike");
  quad_read_wait_a: assert property (
    st.state == S_WAIT && $past(st.state) == S_ADDR && st.cmd == CMD_READ_QUAD
    |-> st.cnt == WAIT_QD_READ - 5'h1)
    else $error("wrong wait count for quad read");
  fast_read_wait_a: assert property (
    st.state == S_WAIT && $past(st.state) == S_ADDR && st.cmd == CMD_READ_FAST && st.wide
    |-> st.cnt == WAIT_QD_FAST - 5'h1)
    else $error("wrong wait count for quad fast read");
  // The column steps by one and wraps on its own width; the row bits never move.
  page_wrap_a: assert property (
    (st.state == S_RDATA || st.state == S_WDATA) && $past(st.state) == st.state
    && $changed(st.addr)
    |-> st.addr[PAGE_W-1:0] == $past(st.addr[PAGE_W-1:0]) + 10'h1
        && st.addr[ADDR_W-1:PAGE_W] == $past(st.addr[ADDR_W-1:PAGE_W]))
    else $error("burst address left its page");
  quad_lanes_a: assert property (
    st.state == S_RDATA && st.cmd == CMD_READ_QUAD && st.dq_oe != '0 |-> st.dq_oe == OE_QUAD)
    else $error("quad read not driving all lanes");

  // Main scenarios: quad read, armed reset, quad exit and a read that wraps its page.
  cover property (cmd_fire && st.quad && cmd_code == CMD_READ_QUAD);
  cover property (cmd_fire && st.armed && cmd_code == CMD_RESET);
  cover property (cmd_fire && st.quad && cmd_code == CMD_QUAD_EXIT);
  cover property (st.state == S_RDATA && st.addr[PAGE_W-1:0] == '1
                  ##[1:40] st.addr[PAGE_W-1:0] == '0);

endmodule // qpsr_cmd
`default_nettype wire

// ### hdl/qpsr_page_mem.sv
`timescale 1ns/100ps
`default_nettype none
module qpsr_page_mem
  import qpsr_pkg::*;
(
  // Clock.
  input  wire logic              clk,
  // Write side.
  input  wire logic              wr_en,
  input  wire logic [PAGE_W-1:0] wr_addr,
  input  wire logic [7:0]        wr_data,
  // Read side.
  input  wire logic [PAGE_W-1:0] rd_addr,
  output logic      [7:0]        rd_data
);

  ////////////////////////////////////////////////////////////////////////////
  // One page of storage; bursts wrap inside it, so the upper address is unused.
  logic [7:0] mem [0:(1<<PAGE_W)-1];

  // Writes land on the clock edge.
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Reads are combinational so a byte is ready on the very edge it is needed.
  assign rd_data = mem[rd_addr];

endmodule // qpsr_page_mem
`default_nettype wire

// ### hdl/qpsr_pkg.sv
package qpsr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Command codes.
  localparam logic [7:0] CMD_READ_SLOW  = 8'h03;
  localparam logic [7:0] CMD_READ_FAST  = 8'h0b;
  localparam logic [7:0] CMD_READ_QUAD  = 8'heb;
  localparam logic [7:0] CMD_WRITE      = 8'h02;
  localparam logic [7:0] CMD_WRITE_QUAD = 8'h38;
  localparam logic [7:0] CMD_QUAD_ENTER = 8'h35;
  localparam logic [7:0] CMD_QUAD_EXIT  = 8'hf5;
  localparam logic [7:0] CMD_RESET_ARM  = 8'h66;
  localparam logic [7:0] CMD_RESET      = 8'h99;

  ////////////////////////////////////////////////////////////////////////////
  // Widths, counts and pin lanes.
  localparam int          ADDR_W        = 24;
  localparam int          PAGE_W        = 10;
  localparam logic [4:0]  ADDR_SER_LAST = 5'h17;  // 24 address bits, one per clock.
  localparam logic [4:0]  ADDR_QD_LAST  = 5'h05;  // 24 address bits, four per clock.
  localparam logic [4:0]  UNIT_SER_LAST = 5'h07;  // Eight bit slots per byte.
  localparam logic [4:0]  UNIT_QD_LAST  = 5'h01;  // Two nibble slots per byte.
  localparam logic [4:0]  WAIT_NONE     = 5'h00;
  localparam logic [4:0]  WAIT_SER_FAST = 5'h08;
  localparam logic [4:0]  WAIT_QD_FAST  = 5'h04;
  localparam logic [4:0]  WAIT_QD_READ  = 5'h06;
  localparam logic [3:0]  OE_SERIAL     = 4'h2;   // Serial data leaves on lane 1.
  localparam logic [3:0]  OE_QUAD       = 4'hf;

  ////////////////////////////////////////////////////////////////////////////
  // Types.
  typedef enum logic [5:0] {
    S_CMD   = 6'h01,
    S_ADDR  = 6'h02,
    S_WAIT  = 6'h04,
    S_RDATA = 6'h08,
    S_WDATA = 6'h10,
    S_SKIP  = 6'h20
  } qpsr_state_t;

  typedef struct packed {
    logic       ce_n;
    logic       sclk;
    logic [3:0] dq;
  } qpsr_pin_in_t;

  typedef struct packed {
    qpsr_state_t         state;
    logic                quad;
    logic                armed;
    logic                wide;
    logic                is_read;
    logic [7:0]          cmd;
    logic [4:0]          cnt;
    logic [4:0]          waits;
    logic [ADDR_W-1:0]   addr;
    logic [ADDR_W-1:0]   sh;
    logic                sclk_prev;
    logic [3:0]          dq_out;
    logic [3:0]          dq_oe;
  } qpsr_regs_t;

endpackage

// ### verification/qpsr_host.sv
`timescale 1ns/100ps
`default_nettype none
module qpsr_host
  import qpsr_pkg::*;
(
  // Clock.
  input  wire logic          clk,
  // Device side.
  input  wire logic [3:0]    dq_out,
  input  wire logic [3:0]    dq_oe,
  output var  qpsr_pin_in_t  pins
);
  logic       ce_n_r = 1'b1;
  logic       sclk_r = 1'b0;
  logic       en     = 1'b0;
  logic [3:0] drv    = 4'h0;
  logic [3:0] idle   = 4'h5;

  // Half-sleep rest and settle times in 40 ns clocks, a little over 4 us and 150 us.
  localparam int NAP_REST   = 101;
  localparam int NAP_SETTLE = 3750;

  ////////////////////////////////////////////////////////////////////////////
  // Released lanes change every cycle, so a stale level can never pass as data.
  always @(posedge clk) idle <= ~idle;

  // Each lane carries whoever drives it.
  always_comb pins = '{ce_n: ce_n_r, sclk: sclk_r,
                       dq: (dq_oe & dq_out) | (~dq_oe & (en ? drv : idle))};

  ////////////////////////////////////////////////////////////////////////////
  // One slot: two clocks low, two high, far slower than any period limit.
  task automatic slot(input logic [3:0] v, input logic d, output logic [3:0] r);
    sclk_r <= 1'b0;
    drv    <= v;
    en     <= d;
    repeat (2) @(posedge clk);
    sclk_r <= 1'b1;
    repeat (2) @(posedge clk);
    r = pins.dq;
  endtask

  // Frames stay short; the longest one used is under 8 us.
  task automatic start;
    ce_n_r <= 1'b0;
    @(posedge clk);
  endtask

  // Select is raised at once after the last slot, and the clock stands low.
  task automatic stop;
    ce_n_r <= 1'b1;
    sclk_r <= 1'b0;
    en     <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // Half-sleep exit: long rest with select high, a short low pulse, then a long settle.
  task automatic nap_exit;
    repeat (NAP_REST) @(posedge clk);
    ce_n_r <= 1'b0;
    repeat (2) @(posedge clk);
    ce_n_r <= 1'b1;
    repeat (NAP_SETTLE) @(posedge clk);
  endtask
endmodule  // qpsr_host
`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import qpsr_pkg::*;
;
  logic         clk = 1'b0;
  logic         nrst = 1'b0;
  qpsr_pin_in_t pins;
  logic [3:0]   dq_out;
  logic [3:0]   dq_oe;
  logic         quad_mode;
  int           bad_count = 0;
  int           cmp_count = 0;

  // Half-sleep entry code; the device does not decode it and must ignore it.
  localparam logic [7:0] CMD_NAP = 8'hc0;

  // A 40 ns clock.
  always #20 clk = ~clk;

  qpsr_cmd i_dut (.clk(clk), .nrst(nrst), .pins(pins), .dq_out(dq_out),
                  .dq_oe(dq_oe), .quad_mode(quad_mode));
  qpsr_host i_host (.clk(clk), .dq_out(dq_out), .dq_oe(dq_oe), .pins(pins));

  ////////////////////////////////////////////////////////////////////////////
  // Comparisons.
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Byte movers: MSB first, a bit on lane 0 or a nibble on all lanes.
  task automatic put(input logic [7:0] b, input logic q);
    logic [3:0] r;
    if (q) begin
      i_host.slot(b[7:4], 1'b1, r);
      i_host.slot(b[3:0], 1'b1, r);
    end else begin
      for (int i = 7; i >= 0; i--) i_host.slot({3'h0, b[i]}, 1'b1, r);
    end
  endtask

  // Serial read data arrives on lane 1, quad data on all four.
  task automatic get(input logic q, output logic [7:0] b);
    logic [3:0] r;
    for (int i = 0; i < (q ? 2 : 8); i++) begin
      i_host.slot(4'h0, 1'b0, r);
      b = q ? {b[3:0], r} : {b[6:0], r[1]};
    end
    chk_val({4'h0, dq_oe}, {4'h0, q ? OE_QUAD : OE_SERIAL});
  endtask

  task automatic hdr(input logic [7:0] c, input logic cq, input logic aq,
                     input logic [23:0] a);
    i_host.start();
    put(c, cq);
    put(a[23:16], aq);
    put(a[15:8], aq);
    put(a[7:0], aq);
  endtask

  task automatic rd(input logic [7:0] c, input logic cq, input logic aq,
                    input logic [23:0] a, input int nw, input logic [7:0] e0,
                    input logic [7:0] e1, input int n);
    logic [3:0] r;
    logic [7:0] b;
    hdr(c, cq, aq, a);
    repeat (nw) i_host.slot(4'h0, 1'b0, r);
    get(aq, b);
    chk_val(b, e0);
    if (n > 1) begin
      get(aq, b);
      chk_val(b, e1);
    end
    i_host.stop();
  endtask

  task automatic wr(input logic [7:0] c, input logic cq, input logic aq,
                    input logic [23:0] a, input logic [7:0] d0, input logic [7:0] d1);
    hdr(c, cq, aq, a);
    put(d0, aq);
    put(d1, aq);
    i_host.stop();
  endtask

  task automatic one(input logic [7:0] c, input logic q);
    i_host.start();
    put(c, q);
    i_host.stop();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_reset;
    chk_flag(quad_mode, 1'b0);
    chk_val({4'h0, dq_oe}, 8'h00);
    $display("test reset done");
  endtask

  // The write crosses the page end, so the second byte lands at offset zero.
  task automatic t_serial;
    wr(CMD_WRITE, 1'b0, 1'b0, 24'h0003ff, 8'ha5, 8'h3c);
    rd(CMD_READ_SLOW, 1'b0, 1'b0, 24'h0003ff, 0, 8'ha5, 8'h3c, 2);
    rd(CMD_READ_FAST, 1'b0, 1'b0, 24'h000400, 8, 8'h3c, 8'h00, 1);
    wr(CMD_WRITE_QUAD, 1'b0, 1'b1, 24'h000020, 8'h9a, 8'hbc);
    rd(CMD_READ_QUAD, 1'b0, 1'b1, 24'h000020, 6, 8'h9a, 8'hbc, 2);
    $display("test serial done");
  endtask

  task automatic t_quad;
    one(CMD_QUAD_EXIT, 1'b0);
    chk_flag(quad_mode, 1'b0);
    one(CMD_QUAD_ENTER, 1'b0);
    chk_flag(quad_mode, 1'b1);
    wr(CMD_WRITE, 1'b1, 1'b1, 24'h000010, 8'h12, 8'h34);
    wr(CMD_WRITE_QUAD, 1'b1, 1'b1, 24'h000012, 8'h56, 8'h78);
    rd(CMD_READ_QUAD, 1'b1, 1'b1, 24'h000010, 6, 8'h12, 8'h34, 2);
    rd(CMD_READ_FAST, 1'b1, 1'b1, 24'h000011, 4, 8'h34, 8'h56, 2);
    $display("test quad done");
  endtask

  // An arm broken by another command must not reset; a clean pair must.
  task automatic t_swreset;
    one(CMD_RESET_ARM, 1'b1);
    rd(CMD_READ_QUAD, 1'b1, 1'b1, 24'h000013, 6, 8'h78, 8'h00, 1);
    one(CMD_RESET, 1'b1);
    chk_flag(quad_mode, 1'b1);
    one(CMD_RESET_ARM, 1'b1);
    one(CMD_RESET, 1'b1);
    chk_flag(quad_mode, 1'b0);
    one(CMD_RESET_ARM, 1'b0);
    one(CMD_RESET, 1'b0);
    chk_flag(quad_mode, 1'b0);
    rd(CMD_READ_SLOW, 1'b0, 1'b0, 24'h000010, 0, 8'h12, 8'h00, 1);
    $display("test software reset done");
  endtask

  task automatic t_exit;
    one(CMD_QUAD_ENTER, 1'b0);
    chk_flag(quad_mode, 1'b1);
    one(CMD_QUAD_EXIT, 1'b1);
    chk_flag(quad_mode, 1'b0);
    rd(CMD_READ_SLOW, 1'b0, 1'b0, 24'h000012, 0, 8'h56, 8'h00, 1);
    $display("test quad exit done");
  endtask

  // Half-sleep is ignored: after the rest, exit pulse and settle the mode and data remain.
  task automatic t_sleep;
    one(CMD_NAP, 1'b0);
    i_host.nap_exit();
    chk_flag(quad_mode, 1'b0);
    rd(CMD_READ_SLOW, 1'b0, 1'b0, 24'h0003ff, 0, 8'ha5, 8'h3c, 2);
    $display("test half sleep done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and run control.
  task automatic give_verdict;
    $display("Counts: compares=%0d mismatches=%0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // A hang is cut short well inside the run budget.
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    give_verdict();
  end

  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset();
    t_serial();
    t_sleep();
    t_quad();
    t_swreset();
    t_exit();
    give_verdict();
  end
endmodule  // tb_top
`default_nettype wire
